// ==== verilog/ddc_i2c_cmd.sv ====
// Overview of operation
// - answer address 00011 plus two pins
// - work at 100 and 400 kHz clock
// - no general call, no long addresses
// - first byte: command nibble, channel nibble
// - then 12-bit code MSB first, four ignored
// - word captured over 24 rising edges
// - decode eight commands, top-bit codes ignored
// - channel nibble: top bit B, bottom A
// - input write loads input register; strobe high: output untouched
// - strobe low: unmasked writes pass through
// - update copies input to output register
// - write-and-update ignores load strobe
// - ack own address on ninth clock
// - readback: control byte, restart, two bytes
// - both channels selected reads channel A
// - reference on at power-up, command disables
// - power command: two mode bits per channel
// - mask command: masked channels ignore strobe
// - strobe fall transfers unmasked input registers
`include "ddc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module ddc_i2c_cmd
  import ddc_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // two-wire bus
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  // straps and strobe
  input wire logic i_addr_sel_pin0,
  input wire logic i_addr_sel_pin1,
  input wire logic i_load_strobe_n,
  // converter stage
  output logic [`DDC_CODE_W-1:0] o_code_a,
  output logic [`DDC_CODE_W-1:0] o_code_b,
  output logic [1:0] o_pwr_mode_a,
  output logic [1:0] o_pwr_mode_b,
  output logic o_ref_en
);

  // bus is oversampled; enough samples per bit are needed to see
  // start/stop between clock edges
  if (`DDC_MCLK_KHZ / `DDC_SCL_FAST_KHZ < `DDC_MIN_OVERSAMPLE) begin : g_rate_chk
    $error("ddc_i2c_cmd: master clock too slow for fast mode");
  end

  ddc_state_t q;
  ddc_state_t next_q;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic ld_fall;
  logic [`DDC_WORD_W-1:0] w;
  logic [3:0] cmd;
  logic sel_a;
  logic sel_b;
  ddc_code_t code;
  logic [7:0] txb;

  function automatic logic [7:0] ddc_tx_byte(input ddc_code_t c, input logic [1:0] idx);
    logic [15:0] full;
    full = {c, 4'h0};
    case (idx)
      2'h0: ddc_tx_byte = full[15:8];
      2'h1: ddc_tx_byte = full[7:0];
      default: ddc_tx_byte = 8'h00;
    endcase
  endfunction : ddc_tx_byte

  function automatic logic [3:0] ddc_inc4(input logic [3:0] v);
    ddc_inc4 = 4'(v + 4'h1);
  endfunction : ddc_inc4

  always_comb begin
    next_q = q;
    // two-flop synchronisers; logic reads the second stage and a delayed copy of it, never the first
    next_q.scl_s1 = i_scl;
    next_q.scl_s2 = q.scl_s1;
    next_q.scl_d = q.scl_s2;
    next_q.sda_s1 = i_sda;
    next_q.sda_s2 = q.sda_s1;
    next_q.sda_d = q.sda_s2;
    next_q.ld_s1 = i_load_strobe_n;
    next_q.ld_s2 = q.ld_s1;
    next_q.ld_d = q.ld_s2;
    next_q.as_s1 = {i_addr_sel_pin1, i_addr_sel_pin0};
    next_q.as_s2 = q.as_s1;

    scl_rise = q.scl_s2 & ~q.scl_d;
    scl_fall = ~q.scl_s2 & q.scl_d;
    bus_start = q.scl_s2 & q.scl_d & q.sda_d & ~q.sda_s2;
    bus_stop = q.scl_s2 & q.scl_d & ~q.sda_d & q.sda_s2;
    ld_fall = q.ld_d & ~q.ld_s2;

    w = {q.word, q.sh};
    cmd = w[`DDC_CMD_MSB:`DDC_CMD_LSB];
    sel_a = w[`DDC_CHAN_A_BIT];
    sel_b = w[`DDC_CHAN_B_BIT];
    code = w[`DDC_CODE_MSB:`DDC_CODE_LSB];
    txb = 8'h00;

    // deferred update on the strobe's falling edge
    if (ld_fall) begin
      if (!q.mask_a) begin
        next_q.out_a = q.in_a;
      end
      if (!q.mask_b) begin
        next_q.out_b = q.in_b;
      end
    end

    if (bus_stop) begin
      next_q.phase = DDC_PH_IDLE;
      next_q.sda_oe_n = 1'b1;
    end else if (bus_start) begin
      // a repeated start also lands here
      next_q.phase = DDC_PH_RX;
      next_q.bitcnt = 4'h0;
      next_q.is_addr = 1'b1;
      next_q.sda_oe_n = 1'b1;
    end else begin
      case (q.phase)
        DDC_PH_RX: begin
          if (scl_rise) begin
            next_q.sh = {q.sh[6:0], q.sda_s2};
            next_q.bitcnt = ddc_inc4(q.bitcnt);
          end
          if (scl_fall && q.bitcnt == 4'h8) begin
            if (q.is_addr) begin
              // only the one 7-bit address; general call not acked
              if (q.sh[7:1] == {`DDC_ADDR_HI, q.as_s2[1], q.as_s2[0]}) begin
                next_q.phase = DDC_PH_RACK;
                next_q.sda_oe_n = 1'b0;
                next_q.rd = q.sh[0];
                next_q.nbytes = 2'h0;
                next_q.txidx = 2'h0;
              end else begin
                next_q.phase = DDC_PH_IDLE;
              end
            end else begin
              next_q.word = w[`DDC_WORD_W-9:0];
              next_q.phase = DDC_PH_RACK;
              next_q.sda_oe_n = 1'b0;
              if (q.nbytes == 2'h0) begin
                // A wins when both channel bits are set
                next_q.rb_sel_b = q.sh[`DDC_CBYTE_B_BIT] & ~q.sh[`DDC_CBYTE_A_BIT];
              end
              if (q.nbytes == `DDC_BYTES_PER_WORD - 2'h1) begin
                next_q.nbytes = 2'h0;
                // word complete on its 24th falling edge
                case (cmd)
                  `DDC_CMD_NOP: begin
                  end
                  `DDC_CMD_WRITE: begin
                    if (sel_a) begin
                      next_q.in_a = code;
                      if (!q.ld_s2 && !q.mask_a) begin
                        next_q.out_a = code;
                      end
                    end
                    if (sel_b) begin
                      next_q.in_b = code;
                      if (!q.ld_s2 && !q.mask_b) begin
                        next_q.out_b = code;
                      end
                    end
                  end
                  `DDC_CMD_UPDATE: begin
                    if (sel_a) begin
                      next_q.out_a = q.in_a;
                    end
                    if (sel_b) begin
                      next_q.out_b = q.in_b;
                    end
                  end
                  `DDC_CMD_WR_UPD: begin
                    if (sel_a) begin
                      next_q.in_a = code;
                      next_q.out_a = code;
                    end
                    if (sel_b) begin
                      next_q.in_b = code;
                      next_q.out_b = code;
                    end
                  end
                  `DDC_CMD_POWER: begin
                    next_q.pd_a = w[`DDC_PD_A_LSB+1:`DDC_PD_A_LSB];
                    next_q.pd_b = w[`DDC_PD_B_LSB+1:`DDC_PD_B_LSB];
                  end
                  `DDC_CMD_MASK: begin
                    // channel nibble is not consulted here
                    next_q.mask_a = w[`DDC_MASK_A_BIT];
                    next_q.mask_b = w[`DDC_MASK_B_BIT];
                  end
                  `DDC_CMD_SRESET: begin
                    next_q.in_a = `DDC_CODE_RST;
                    next_q.in_b = `DDC_CODE_RST;
                    next_q.out_a = `DDC_CODE_RST;
                    next_q.out_b = `DDC_CODE_RST;
                    next_q.pd_a = `DDC_PD_RST;
                    next_q.pd_b = `DDC_PD_RST;
                    next_q.mask_a = `DDC_MASK_RST;
                    next_q.mask_b = `DDC_MASK_RST;
                    next_q.ref_en = `DDC_REF_EN_RST;
                  end
                  `DDC_CMD_REFSET: begin
                    next_q.ref_en = ~w[`DDC_REF_OFF_BIT];
                  end
                  default: begin
                    // reserved codes change nothing
                  end
                endcase
              end else begin
                next_q.nbytes = 2'(q.nbytes + 2'h1);
              end
            end
          end
        end
        DDC_PH_RACK: begin
          if (scl_fall) begin
            next_q.is_addr = 1'b0;
            next_q.sda_oe_n = 1'b1;
            if (q.rd) begin
              txb = ddc_tx_byte(q.rb_sel_b ? q.in_b : q.in_a, 2'h0);
              next_q.phase = DDC_PH_TX;
              next_q.sh = txb;
              next_q.sda_oe_n = txb[7];
              next_q.bitcnt = 4'h1;
            end else begin
              next_q.phase = DDC_PH_RX;
              next_q.bitcnt = 4'h0;
            end
          end
        end
        DDC_PH_TX: begin
          if (scl_fall) begin
            if (q.bitcnt == 4'h8) begin
              next_q.phase = DDC_PH_TACK;
              next_q.sda_oe_n = 1'b1;
            end else begin
              next_q.sh = {q.sh[6:0], 1'b0};
              next_q.sda_oe_n = q.sh[6];
              next_q.bitcnt = ddc_inc4(q.bitcnt);
            end
          end
        end
        DDC_PH_TACK: begin
          if (scl_rise) begin
            next_q.nack = q.sda_s2;
          end
          if (scl_fall) begin
            if (q.nack) begin
              next_q.phase = DDC_PH_IDLE;
            end else begin
              // past the second byte the device sends zeros
              next_q.txidx = (q.txidx == 2'h3) ? q.txidx : 2'(q.txidx + 2'h1);
              txb = ddc_tx_byte(q.rb_sel_b ? q.in_b : q.in_a, next_q.txidx);
              next_q.phase = DDC_PH_TX;
              next_q.sh = txb;
              next_q.sda_oe_n = txb[7];
              next_q.bitcnt = 4'h1;
            end
          end
        end
        DDC_PH_IDLE: begin
          next_q.sda_oe_n = 1'b1;
        end
        default: begin
          next_q.phase = DDC_PH_IDLE;
          next_q.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_d <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_d <= 1'b1;
      q.ld_s1 <= 1'b1;
      q.ld_s2 <= 1'b1;
      q.ld_d <= 1'b1;
      q.sda_oe_n <= 1'b1;
      q.ref_en <= `DDC_REF_EN_RST;
    end else begin
      q <= next_q;
    end
  end

  // open-drain: only ever pulls low
  assign o_sda = 1'b0;
  assign o_sda_oe_n = q.sda_oe_n;
  assign o_code_a = q.out_a;
  assign o_code_b = q.out_b;
  assign o_pwr_mode_a = q.pd_a;
  assign o_pwr_mode_b = q.pd_b;
  assign o_ref_en = q.ref_en;

endmodule : ddc_i2c_cmd

`default_nettype wire

// ==== verilog/ddc_cfg.svh ====
`ifndef DDC_CFG_SVH
`define DDC_CFG_SVH

// bus address: fixed upper bits, low two from the select pins
`define DDC_ADDR_HI 5'h03
`define DDC_ADDR_LEN 7

// clock figures
`define DDC_MCLK_KHZ 200000
`define DDC_SCL_STD_KHZ 100
`define DDC_SCL_FAST_KHZ 400
`define DDC_MIN_OVERSAMPLE 16

// shift word layout
`define DDC_WORD_W 24
`define DDC_CODE_W 12
`define DDC_CMD_MSB 23
`define DDC_CMD_LSB 20
`define DDC_CHAN_B_BIT 19
`define DDC_CHAN_A_BIT 16
`define DDC_CODE_MSB 15
`define DDC_CODE_LSB 4
`define DDC_BYTES_PER_WORD 2'h3

// command codes
`define DDC_CMD_NOP 4'h0
`define DDC_CMD_WRITE 4'h1
`define DDC_CMD_UPDATE 4'h2
`define DDC_CMD_WR_UPD 4'h3
`define DDC_CMD_POWER 4'h4
`define DDC_CMD_MASK 4'h5
`define DDC_CMD_SRESET 4'h6
`define DDC_CMD_REFSET 4'h7

// command data fields in the shift word's low byte; readback channel bits in the control byte
`define DDC_PD_A_LSB 0
`define DDC_PD_B_LSB 6
`define DDC_MASK_A_BIT 0
`define DDC_MASK_B_BIT 3
`define DDC_REF_OFF_BIT 0
`define DDC_CBYTE_A_BIT 0
`define DDC_CBYTE_B_BIT 3

// reset values
`define DDC_CODE_RST 12'h000
`define DDC_PD_RST 2'h0
`define DDC_MASK_RST 1'h0
`define DDC_REF_EN_RST 1'h1

`endif

// ==== verilog/ddc_pkg.sv ====
`include "ddc_cfg.svh"

package ddc_pkg;

  typedef enum logic [2:0] {
    DDC_PH_IDLE,
    DDC_PH_RX,
    DDC_PH_RACK,
    DDC_PH_TX,
    DDC_PH_TACK
  } ddc_phase_t;

  typedef logic [`DDC_CODE_W-1:0] ddc_code_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic ld_s1;
    logic ld_s2;
    logic ld_d;
    logic [1:0] as_s1;
    logic [1:0] as_s2;
    ddc_phase_t phase;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic is_addr;
    logic rd;
    logic nack;
    logic [1:0] nbytes;
    logic [1:0] txidx;
    logic rb_sel_b;
    logic [`DDC_WORD_W-9:0] word;
    logic sda_oe_n;
    ddc_code_t in_a;
    ddc_code_t in_b;
    ddc_code_t out_a;
    ddc_code_t out_b;
    logic [1:0] pd_a;
    logic [1:0] pd_b;
    logic mask_a;
    logic mask_b;
    logic ref_en;
  } ddc_state_t;

endpackage : ddc_pkg

// ==== verif/ddc_i2c_cmd_sva.sv ====
`timescale 1ns/100ps
`default_nettype none

module ddc_i2c_cmd_sva (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // bus and straps
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe_n,
  input wire logic i_addr_sel_pin0,
  input wire logic i_addr_sel_pin1,
  input wire logic i_load_strobe_n,
  // converter stage
  input wire logic [11:0] o_code_a,
  input wire logic [11:0] o_code_b,
  input wire logic [1:0] o_pwr_mode_a,
  input wire logic [1:0] o_pwr_mode_b,
  input wire logic o_ref_en
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic ld_q;
  logic [3:0] since_fall;
  // strobe-driven updates land a few cycles after the pin falls
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ld_q <= 1'b1;
      since_fall <= 4'hF;
    end else begin
      ld_q <= i_load_strobe_n;
      since_fall <= (ld_q && !i_load_strobe_n) ? 4'h0 : ((since_fall == 4'hF) ? 4'hF : since_fall + 4'h1);
    end
  end
  reset_values_a: assert property ($fell(i_rst) |-> o_sda_oe_n && o_ref_en &&
    o_code_a == 12'h000 && o_code_b == 12'h000 && o_pwr_mode_a == 2'h0 && o_pwr_mode_b == 2'h0)
    else $error("outputs not at reset state");
  sda_drive_zero_a: assert property (o_sda == 1'b0) else $error("data drive not low");
  sda_edge_low_a: assert property ($changed(o_sda_oe_n) |-> !i_scl) else $error("sda moved with scl high");
  ack_hold_a: assert property (!o_sda_oe_n && $rose(i_scl) |-> !o_sda_oe_n [*8])
    else $error("sda released during scl high");
  pwr_change_a: assert property ($changed({o_pwr_mode_a, o_pwr_mode_b}) |-> !i_scl)
    else $error("power mode changed outside command");
  ref_change_a: assert property ($changed(o_ref_en) |-> !i_scl) else $error("reference changed outside command");
  code_a_strobe_a: assert property ($changed(o_code_a) && i_scl |-> since_fall < 4'h8)
    else $error("code a changed without strobe");
  code_b_strobe_a: assert property ($changed(o_code_b) && i_scl |-> since_fall < 4'h8)
    else $error("code b changed without strobe");
  cover property ($fell(o_sda_oe_n));
  cover property ($fell(o_ref_en));
  cover property ($changed(o_code_b) && i_scl);
endmodule : ddc_i2c_cmd_sva

bind ddc_i2c_cmd ddc_i2c_cmd_sva chk_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_addr_sel_pin0(i_addr_sel_pin0),
  .i_addr_sel_pin1(i_addr_sel_pin1), .i_load_strobe_n(i_load_strobe_n), .o_code_a(o_code_a),
  .o_code_b(o_code_b), .o_pwr_mode_a(o_pwr_mode_a), .o_pwr_mode_b(o_pwr_mode_b), .o_ref_en(o_ref_en));

`default_nettype wire

// ==== verif/ddc_mst_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module ddc_mst_model (
  input wire logic i_mclk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // bus idles high; this model alone drives SCL, while SDA is shared with the slave's open-drain pull-down
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // quarter bit of 10 mclk keeps the slave well oversampled
  task automatic hp();
    repeat (10) @(posedge i_mclk);
    #1;
  endtask : hp
  task automatic start();
    o_sda = 1'b1; hp(); o_scl = 1'b1; hp(); o_sda = 1'b0; hp(); o_scl = 1'b0; hp();
  endtask : start
  task automatic stop();
    o_sda = 1'b0; hp(); o_scl = 1'b1; hp(); o_sda = 1'b1; hp();
  endtask : stop
  task automatic bitx(input logic b, output logic r);
    o_sda = b; hp(); o_scl = 1'b1; hp(); r = i_sda; hp(); o_scl = 1'b0; hp();
  endtask : bitx
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(nack, r);
  endtask : rbyte
endmodule : ddc_mst_model

`default_nettype wire

// ==== verif/ddc_i2c_cmd_test.sv ====
`timescale 1ns/100ps
`default_nettype none

module ddc_i2c_cmd_test;
  localparam logic [6:0] ADR = 7'h0E;
  logic i_mclk, i_rst, scl, m_sda, o_sda, oe_n, ldn, sda_w, ack;
  logic [11:0] code_a, code_b;
  logic [1:0] pm_a, pm_b;
  logic ref_en;
  int n_errors, samples_checked, cyc;
  // open-drain line with pull-up
  assign sda_w = m_sda & (oe_n | o_sda);
  ddc_mst_model mst_u (.i_mclk(i_mclk), .i_sda(sda_w), .o_scl(scl), .o_sda(m_sda));
  ddc_i2c_cmd dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_w), .o_sda(o_sda),
    .o_sda_oe_n(oe_n), .i_addr_sel_pin0(1'b0), .i_addr_sel_pin1(1'b1), .i_load_strobe_n(ldn),
    .o_code_a(code_a), .o_code_b(code_b), .o_pwr_mode_a(pm_a), .o_pwr_mode_b(pm_b), .o_ref_en(ref_en));
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic [6:0] a, input logic [7:0] cb, input logic [15:0] d, input logic ackx);
    mst_u.start();
    mst_u.wbyte({a, 1'b0}, ack);
    chk(12'(ack), 12'(ackx));
    if (ackx) begin
      mst_u.wbyte(cb, ack);
      chk(12'(ack), 12'h001);
      mst_u.wbyte(d[15:8], ack);
      chk(12'(ack), 12'h001);
      mst_u.wbyte(d[7:0], ack);
      chk(12'(ack), 12'h001);
    end
    mst_u.stop();
    mst_u.hp();
  endtask : xfer
  task automatic rdback(input logic [7:0] cb, input logic [11:0] exp);
    logic [7:0] h, l;
    mst_u.start();
    mst_u.wbyte({ADR, 1'b0}, ack);
    mst_u.wbyte(cb, ack);
    mst_u.start();
    mst_u.wbyte({ADR, 1'b1}, ack);
    chk(12'(ack), 12'h001);
    mst_u.rbyte(1'b0, h);
    mst_u.rbyte(1'b1, l);
    mst_u.stop();
    chk({h, l[7:4]}, exp);
    chk(12'(l[3:0]), 12'h000);
  endtask : rdback
  task automatic strobe(input logic v);
    @(posedge i_mclk);
    #1 ldn = v;
    repeat (10) @(posedge i_mclk);
  endtask : strobe
  initial begin
    cyc = 0;
    forever begin
      @(posedge i_mclk);
      cyc++;
      if (cyc == 90000) begin
        n_errors++;
        tally_and_finish();
      end
    end
  end
  initial begin
    n_errors = 0;
    samples_checked = 0;
    i_rst = 1'b1;
    ldn = 1'b1;
    repeat (12) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    mst_u.hp();
    chk({pm_a, pm_b, 7'h0, ref_en}, 12'h001);
    chk(code_a | code_b, 12'h000);
    $display("reset test done");
    xfer(7'h0C, 8'h31, 16'hABC0, 1'b0);
    xfer(7'h00, 8'h31, 16'hABC0, 1'b0);
    chk(code_a, 12'h000);
    xfer(ADR, 8'h31, 16'hABC0, 1'b1);
    chk(code_a, 12'hABC);
    chk(code_b, 12'h000);
    $display("address test done");
    xfer(ADR, 8'h18, 16'h1230, 1'b1);
    chk(code_b, 12'h000);
    rdback(8'h08, 12'h123);
    strobe(1'b0);
    chk(code_b, 12'h123);
    strobe(1'b1);
    xfer(ADR, 8'h11, 16'h5550, 1'b1);
    chk(code_a, 12'hABC);
    xfer(ADR, 8'h21, 16'h0000, 1'b1);
    chk(code_a, 12'h555);
    $display("update test done");
    xfer(ADR, 8'h39, 16'hFFF0, 1'b1);
    chk(code_a & code_b, 12'hFFF);
    xfer(ADR, 8'h11, 16'h0A50, 1'b1);
    rdback(8'h09, 12'h0A5);
    xfer(ADR, 8'h50, 16'h0008, 1'b1);
    strobe(1'b0);
    xfer(ADR, 8'h19, 16'h0F00, 1'b1);
    chk(code_a, 12'h0F0);
    chk(code_b, 12'hFFF);
    strobe(1'b1);
    $display("strobe test done");
    xfer(ADR, 8'h40, 16'h00FD, 1'b1);
    chk({8'h0, pm_b, pm_a}, 12'h00D);
    xfer(ADR, 8'h70, 16'h0001, 1'b1);
    chk(12'(ref_en), 12'h000);
    xfer(ADR, 8'h09, 16'h7770, 1'b1);
    for (int c = 8; c < 16; c++) xfer(ADR, {4'(c), 4'h9}, 16'h1230, 1'b1);
    chk(code_a, 12'h0F0);
    chk(code_b, 12'hFFF);
    $display("command test done");
    xfer(ADR, 8'h60, 16'h0000, 1'b1);
    chk(code_a | code_b, 12'h000);
    chk({pm_a, pm_b, 7'h0, ref_en}, 12'h001);
    $display("soft reset test done");
    tally_and_finish();
  end
endmodule : ddc_i2c_cmd_test

`default_nettype wire
